// ### bench/fpc_flash_model.sv
// Behavioural flash: logs writes, answers status polls.
// Pins come from the sequencer; mode_in 1 fails, 2 aborts.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_flash_model (
   input wire logic [21:0] addr_in,
   input wire logic [15:0] dq_in,
   input wire logic        dq_oe_in,
   input wire logic        ce_n_in,
   input wire logic        we_n_in,
   input wire logic        oe_n_in,
   input wire logic        reset_n_in,
   input wire logic [1:0]  mode_in,
   output logic [15:0]     dq_out
);
   logic [37:0] wlog[$];
   logic [21:0] la = 0;
   logic [21:0] lda = 0;
   logic        susp = 0;
   logic [15:0] ld = 0;
   logic [15:0] prev = 0;
   logic [15:0] rd = 0;
   logic        tog = 0;
   int          busy = 0;
   // Unselected lines invert, so a stale value never passes
   assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
   always @(negedge we_n_in) la = addr_in;
   always @(posedge we_n_in) begin
      // Suspend and resume get through while busy; the countdown holds meanwhile
      if (!ce_n_in && dq_oe_in && busy > 0) susp = (dq_in == 16'h00b0) | (susp & (dq_in != 16'h0030));
      if (!ce_n_in && dq_oe_in && reset_n_in && busy == 0) begin
         wlog.push_back({la, dq_in});
         if (prev == `FPC_CMD_PGM || dq_in == `FPC_CMD_CONFIRM) busy = 3;
         if (dq_in != `FPC_CMD_CONFIRM) begin
            ld  = dq_in;
            lda = la;
         end
         prev = dq_in;
      end
   end
   always @(negedge oe_n_in) begin
      tog = ~tog;
      if (busy > 0 && !susp) busy--;
      if (busy > 0 || mode_in != 2'h0) rd = {8'h00, ~ld[7], tog, mode_in == 2'h1, 3'h0, mode_in == 2'h2, 1'b0};
      else rd = (addr_in == lda) ? ld : ~ld;
      // A failed or aborted operation is over, so the reset commands must get through
      if (mode_in != 2'h0) busy = 0;
   end
   always @(negedge reset_n_in) begin
      busy = 0;
      prev = 0;
      susp = 0;
   end
endmodule : fpc_flash_model
`default_nettype wire

// ### bench/fpc_seq_top_asserts.sv
// Port-level checks on the flash program sequencer.
// Bound to fpc_seq_top; one clock, reset rst_n_in.
`timescale 1ns/1ps
`default_nettype none
module fpc_seq_top_asserts (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   input wire logic flash_dq_oe_out,
   input wire logic flash_ce_n_out,
   input wire logic flash_we_n_out,
   input wire logic flash_oe_n_out,
   input wire logic flash_reset_n_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_wait_one: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
      else $error("waitrequest low longer than one cycle");
   a_wait_cause: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
      else $error("answer without request");
   a_write_pulse: assert property ($fell(flash_we_n_out) |-> !$past(flash_ce_n_out) ##1 flash_we_n_out)
      else $error("write strobe badly framed");
   a_data_hold: assert property ($rose(flash_we_n_out) |-> !flash_ce_n_out && flash_dq_oe_out)
      else $error("data released before write strobe rose");
   a_read_len: assert property ($fell(flash_oe_n_out) |-> !flash_ce_n_out ##1 !flash_oe_n_out ##1 flash_oe_n_out)
      else $error("read strobe not two cycles");
   a_no_contend: assert property (!flash_oe_n_out |-> !flash_dq_oe_out && flash_we_n_out)
      else $error("data lines driven during read");
   a_hw_reset: assert property ($fell(flash_reset_n_out) |->
      !flash_reset_n_out[*8] ##1 !flash_reset_n_out ##1 !flash_reset_n_out ##1 flash_reset_n_out)
      else $error("hardware reset pulse not ten cycles");
   a_reset_quiet: assert property (!flash_reset_n_out |-> flash_ce_n_out && flash_we_n_out)
      else $error("bus cycle during hardware reset");
endmodule : fpc_seq_top_asserts
bind fpc_seq_top fpc_seq_top_asserts u_fpc_seq_top_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
   .flash_dq_oe_out(flash_dq_oe_out), .flash_ce_n_out(flash_ce_n_out), .flash_we_n_out(flash_we_n_out),
   .flash_oe_n_out(flash_oe_n_out), .flash_reset_n_out(flash_reset_n_out));
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the flash program sequencer.
// Avalon tasks drive the slave; the flash model answers the pins.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module tb_top;
   logic        clk_in = 0, rst_n_in = 0, rd = 0, wr = 0, wq, oe, ce_n, we_n, oe_n, frst_n;
   logic [4:0]  adr = 0;
   logic [31:0] wd = 0, rq, q;
   logic [21:0] fa;
   logic [15:0] fdo, fdi;
   logic [1:0]  mode = 0;
   int          n_mismatch = 0, cmp_count = 0;
   always #25 clk_in = ~clk_in;
   fpc_seq_top u_fpc_seq_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rq),
      .avs_waitrequest_out(wq), .flash_addr_out(fa), .flash_dq_in(fdi), .flash_dq_out(fdo),
      .flash_dq_oe_out(oe), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
      .flash_reset_n_out(frst_n));
   fpc_flash_model u_fpc_flash_model (.addr_in(fa), .dq_in(fdo), .dq_oe_in(oe), .ce_n_in(ce_n),
      .we_n_in(we_n), .oe_n_in(oe_n), .reset_n_in(frst_n), .mode_in(mode), .dq_out(fdi));
   task automatic conclude;
      $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input logic [39:0] s, input logic [39:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int i;
      i = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk_in);
         i++;
      end while (wq !== 1'b0 && i < 40);
      q = rq;
      if (i >= 40) begin
         n_mismatch++;
         conclude();
      end
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_in);
   endtask : bus
   // Issue an order, then poll status until the sequencer is idle
   task automatic op(input logic [3:0] c);
      int i;
      bus(1'b1, `FPC_REG_CTRL, {28'h0, c});
      for (i = 0; i < 300; i++) begin
         bus(1'b0, `FPC_REG_STATUS, 32'h0);
         if (q[`FPC_ST_BUSY] === 1'b0) break;
      end
      if (i == 300) begin
         n_mismatch++;
         conclude();
      end
   endtask : op
   task automatic ew(input logic [21:0] a, input logic [15:0] d);
      if (u_fpc_flash_model.wlog.size() == 0) chk(40'h1, 40'h0);
      else chk(u_fpc_flash_model.wlog.pop_front(), {a, d});
   endtask : ew
   task automatic unl;
      ew(`FPC_UNLK_A1, `FPC_UNLK_D1);
      ew(`FPC_UNLK_A2, `FPC_UNLK_D2);
   endtask : unl
   task automatic t_word;
      bus(1'b1, `FPC_REG_ADDR, 32'h1234);
      bus(1'b1, `FPC_REG_DATA, 32'hbeef);
      op(4'h1);
      unl();
      ew(`FPC_UNLK_A1, `FPC_CMD_PGM);
      ew(22'h1234, 16'hbeef);
      chk(u_fpc_flash_model.wlog.size(), 0);
      chk(q[`FPC_ST_OK], 1);
      chk(q[31:16], 16'hbeef);
   endtask : t_word
   task automatic t_bypass;
      bus(1'b1, `FPC_REG_ADDR, 32'h40);
      op(4'h2);
      unl();
      ew(`FPC_UNLK_A1, `FPC_CMD_BYPASS);
      chk(q[`FPC_ST_BYP], 1);
      op(4'h1);
      chk(q[`FPC_ST_REFUSE], 1);
      bus(1'b1, `FPC_REG_DATA, 32'h5a5a);
      op(4'h3);
      ew(22'h40, `FPC_CMD_PGM);
      ew(22'h40, 16'h5a5a);
      op(4'h4);
      ew(22'h40, `FPC_CMD_EXIT1);
      ew(22'h40, `FPC_CMD_EXIT2);
      chk({u_fpc_flash_model.wlog.size(), q[`FPC_ST_BYP]}, 0);
   endtask : t_bypass
   task automatic t_buf;
      int i;
      bus(1'b1, `FPC_REG_ADDR, 32'h120);
      bus(1'b1, `FPC_REG_COUNT, 32'h10);
      op(4'h5);
      chk({u_fpc_flash_model.wlog.size(), q[`FPC_ST_REFUSE]}, 1);
      bus(1'b1, `FPC_REG_COUNT, 32'hf);
      for (i = 0; i < 16; i++) bus(1'b1, `FPC_REG_BUFDATA, 32'h100 + i);
      op(4'h5);
      unl();
      ew(22'h120, `FPC_CMD_LOAD);
      ew(22'h120, 16'hf);
      for (i = 0; i < 16; i++) ew(22'h120 + i, 16'h100 + i);
      ew(22'h120, `FPC_CMD_CONFIRM);
      chk(q[`FPC_ST_OK], 1);
      chk(q[31:16], 16'h010f);
   endtask : t_buf
   task automatic t_abort;
      mode <= 2'h2;
      bus(1'b1, `FPC_REG_COUNT, 32'h0);
      bus(1'b1, `FPC_REG_BUFDATA, 32'h77);
      op(4'h5);
      u_fpc_flash_model.wlog.delete();
      chk(q[`FPC_ST_ABORT], 1);
      op(4'h1);
      chk(q[`FPC_ST_REFUSE], 1);
      mode <= 2'h0;
      op(4'h7);
      unl();
      ew(`FPC_UNLK_A1, `FPC_CMD_RESET);
      chk(q[`FPC_ST_ABORT], 0);
   endtask : t_abort
   task automatic t_fail;
      mode <= 2'h1;
      op(4'h1);
      u_fpc_flash_model.wlog.delete();
      chk(q[`FPC_ST_FAIL], 1);
      op(4'h5);
      chk(q[`FPC_ST_REFUSE], 1);
      mode <= 2'h0;
      op(4'h6);
      ew(22'h120, `FPC_CMD_RESET);
      chk(q[`FPC_ST_FAIL], 0);
   endtask : t_fail
   task automatic t_hw;
      bus(1'b1, `FPC_REG_CTRL, 32'h1);
      op(4'h8);
      chk(q[`FPC_ST_OK], 1);
      u_fpc_flash_model.wlog.delete();
      t_word();
   endtask : t_hw
   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      t_word();
      t_bypass();
      t_buf();
      t_abort();
      t_fail();
      t_hw();
      conclude();
   end
endmodule : tb_top
`default_nettype wire

// ### hdl/fpc_consts.svh
// Offsets, fields, command codes and timing counts of the program sequencer.
// Included by the design files; definitions only.
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define FPC_REG_CTRL    5'h00
`define FPC_REG_ADDR    5'h04
`define FPC_REG_DATA    5'h08
`define FPC_REG_COUNT   5'h0c
`define FPC_REG_BUFDATA 5'h10
`define FPC_REG_STATUS  5'h14

// Status fields
`define FPC_ST_BUSY   0
`define FPC_ST_OK     1
`define FPC_ST_FAIL   2
`define FPC_ST_ABORT  3
`define FPC_ST_BYP    4
`define FPC_ST_REFUSE 5
`define FPC_ST_DATA_LO 16

// Flash status bits on the data lines
`define FPC_DQ_TOGGLE 6
`define FPC_DQ_FAIL   5
`define FPC_DQ_ABORT  1

// Command values and unlock defaults
`define FPC_CMD_PGM     16'h00a0
`define FPC_CMD_BYPASS  16'h0020
`define FPC_CMD_EXIT1   16'h0090
`define FPC_CMD_EXIT2   16'h0000
`define FPC_CMD_RESET   16'h00f0
`define FPC_CMD_LOAD    16'h0025
`define FPC_CMD_CONFIRM 16'h0029
`define FPC_UNLK_A1     22'h000555
`define FPC_UNLK_D1     16'h00aa
`define FPC_UNLK_A2     22'h0002aa
`define FPC_UNLK_D2     16'h0055
`define FPC_BUF_MAX     5'h0f

// Timing
`define FPC_CLK_NS   50
`define FPC_T_WP_NS  35
`define FPC_T_ACC_NS 70
`define FPC_T_RP_NS  500
`define FPC_WP_CYC  ((`FPC_T_WP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_ACC_CYC ((`FPC_T_ACC_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_RP_CYC  ((`FPC_T_RP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

`endif

// ### hdl/fpc_cyc_if.sv
// One flash bus cycle request between sequencer and pin engine.
// Both ends share clk_in.
`timescale 1ns/1ps
`default_nettype none
interface fpc_cyc_if;
   logic        req;
   logic        wr;
   logic [21:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        ack;
   modport seq (output req, wr, addr, wdata, input rdata, ack);
   modport eng (input req, wr, addr, wdata, output rdata, ack);
endinterface : fpc_cyc_if
`default_nettype wire

// ### hdl/fpc_cycle.sv
// Pin engine: turns one request into a flash write or read cycle.
// Assumes pins synchronous to clk_in; request held until ack.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_cycle (
   input  wire logic   clk_in,
   input  wire logic   rst_n_in,
   input  wire logic   ce_in,
   fpc_cyc_if.eng      cyc,
   input  wire logic [15:0] dq_in,
   output logic [21:0] addr_out,
   output logic [15:0] dq_out,
   output logic        dq_oe_out,
   output logic        ce_n_out,
   output logic        we_n_out,
   output logic        oe_n_out
);
   import fpc_pkg::*;
   logic [1:0] stg_ff;
   logic [3:0] cnt_ff;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stg_ff    <= 2'h0;
         cnt_ff    <= 4'h0;
         addr_out  <= 22'h0;
         dq_out    <= 16'h0;
         dq_oe_out <= 1'b0;
         ce_n_out  <= 1'b1;
         we_n_out  <= 1'b1;
         oe_n_out  <= 1'b1;
         cyc.ack   <= 1'b0;
         cyc.rdata <= 16'h0;
      end else if (ce_in) begin
         cyc.ack <= 1'b0;
         unique case (stg_ff)
            2'h0: if (cyc.req && !cyc.ack) begin
               // Address settles before the strobe falls
               addr_out  <= cyc.addr;
               dq_out    <= cyc.wdata;
               dq_oe_out <= cyc.wr;
               ce_n_out  <= 1'b0;
               stg_ff    <= 2'h1;
            end
            2'h1: begin
               we_n_out <= ~cyc.wr;
               oe_n_out <= cyc.wr;
               cnt_ff   <= cyc.wr ? 4'(`FPC_WP_CYC) : 4'(`FPC_ACC_CYC);
               stg_ff   <= 2'h2;
            end
            2'h2: if (cnt_ff == 4'h1) begin
               // Data stays driven past the rising strobe
               we_n_out  <= 1'b1;
               oe_n_out  <= 1'b1;
               cyc.rdata <= dq_in;
               stg_ff    <= 2'h3;
            end else begin
               cnt_ff <= cnt_ff - 4'h1;
            end
            2'h3: begin
               ce_n_out  <= 1'b1;
               dq_oe_out <= 1'b0;
               cyc.ack   <= 1'b1;
               stg_ff    <= 2'h0;
            end
         endcase
      end
   end
endmodule : fpc_cycle
`default_nettype wire

// ### hdl/fpc_pkg.sv
// Types of the flash program sequencer.
// Needs no other file.
package fpc_pkg;
   typedef enum logic [3:0] {
      OP_NONE      = 4'h0,
      OP_WORD      = 4'h1,
      OP_BYP_ENTER = 4'h2,
      OP_BYP_PGM   = 4'h3,
      OP_BYP_EXIT  = 4'h4,
      OP_BUF       = 4'h5,
      OP_RST       = 4'h6,
      OP_ABORT_RST = 4'h7,
      OP_HWRST     = 4'h8
   } fpc_op_type;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_ISSUE = 5'b00010,
      ST_POLL1 = 5'b00100,
      ST_POLL2 = 5'b01000,
      ST_HWRST = 5'b10000
   } fpc_state_type;
endpackage : fpc_pkg

// ### hdl/fpc_seq_top.sv
// Host-side flash program sequencer with Avalon-MM register slave.
// Assumes flash pins synchronous to clk_in, 20 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_seq_top #(
   parameter logic [21:0] UNLK_ADDR1 = `FPC_UNLK_A1,
   parameter logic [15:0] UNLK_DATA1 = `FPC_UNLK_D1,
   parameter logic [21:0] UNLK_ADDR2 = `FPC_UNLK_A2,
   parameter logic [15:0] UNLK_DATA2 = `FPC_UNLK_D2
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic [21:0]      flash_addr_out,
   input  wire logic [15:0] flash_dq_in,
   output logic [15:0]      flash_dq_out,
   output logic             flash_dq_oe_out,
   output logic             flash_ce_n_out,
   output logic             flash_we_n_out,
   output logic             flash_oe_n_out,
   output logic             flash_reset_n_out
);
   import fpc_pkg::*;

   logic          rst_meta_ff;
   logic          rst_n;
   fpc_state_type state_ff;
   fpc_op_type    op_ff;
   fpc_op_type    go_op;
   logic [5:0]    step_ff;
   logic [21:0]   addr_ff;
   logic [15:0]   data_ff;
   logic [4:0]    cnt_ff;
   logic [3:0]    bptr_ff;
   logic [15:0]   r1_ff;
   logic [15:0]   rd_last_ff;
   logic [7:0]    hw_cnt_ff;
   logic          hw_pend_ff;
   logic          ok_ff;
   logic          fail_ff;
   logic          abort_ff;
   logic          byp_ff;
   logic          refused_ff;
   logic          bus_wr;
   logic          go;
   logic          idle;
   logic          allowed;
   logic          unl;
   logic          s_last;
   logic          s_poll;
   logic [21:0]   s_addr;
   logic [15:0]   s_data;
   logic [21:0]   poll_addr;
   logic [3:0]    buf_idx;
   logic [15:0]   buf_data;
   logic [31:0]   status;

   fpc_cyc_if cyc ();

   // Reset release through two flops
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   fpc_cycle u_cycle (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n),
      .ce_in     (ce_in),
      .cyc       (cyc.eng),
      .dq_in     (flash_dq_in),
      .addr_out  (flash_addr_out),
      .dq_out    (flash_dq_out),
      .dq_oe_out (flash_dq_oe_out),
      .ce_n_out  (flash_ce_n_out),
      .we_n_out  (flash_we_n_out),
      .oe_n_out  (flash_oe_n_out)
   );

   fpc_wbuf u_wbuf (
      .clk_in      (clk_in),
      .ce_in       (ce_in),
      .wr_in       (bus_wr && avs_address_in == `FPC_REG_BUFDATA && idle),
      .wr_idx_in   (bptr_ff),
      .wr_data_in  (avs_writedata_in[15:0]),
      .rd_idx_in   (buf_idx),
      .rd_data_out (buf_data)
   );

   assign idle   = (state_ff == ST_IDLE) && !hw_pend_ff;
   assign bus_wr = avs_write_in && !avs_waitrequest_out;
   assign go     = bus_wr && avs_address_in == `FPC_REG_CTRL;
   assign go_op  = fpc_op_type'(avs_writedata_in[3:0]);
   assign status = {rd_last_ff, 10'h0, refused_ff, byp_ff, abort_ff, fail_ff, ok_ff, !idle};

   // Avalon slave: one wait cycle, then answer
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0;
      end else if (ce_in) begin
         if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            if (avs_read_in) begin
               unique case (avs_address_in)
                  `FPC_REG_ADDR:   avs_readdata_out <= {10'h0, addr_ff};
                  `FPC_REG_DATA:   avs_readdata_out <= {16'h0, data_ff};
                  `FPC_REG_COUNT:  avs_readdata_out <= {23'h0, bptr_ff, cnt_ff};
                  `FPC_REG_STATUS: avs_readdata_out <= status;
                  default:         avs_readdata_out <= 32'h0;
               endcase
            end
         end else begin
            avs_waitrequest_out <= 1'b1;
         end
      end
   end

   // Operation parameters, frozen while busy
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         addr_ff <= 22'h0;
         data_ff <= 16'h0;
         cnt_ff  <= 5'h0;
         bptr_ff <= 4'h0;
      end else if (ce_in && bus_wr && idle) begin
         unique case (avs_address_in)
            `FPC_REG_ADDR: addr_ff <= avs_writedata_in[21:0];
            `FPC_REG_DATA: data_ff <= avs_writedata_in[15:0];
            `FPC_REG_COUNT: begin
               cnt_ff  <= avs_writedata_in[4:0];
               bptr_ff <= 4'h0;
            end
            `FPC_REG_BUFDATA: bptr_ff <= bptr_ff + 4'h1;
            default: ;
         endcase
      end
   end

   // Which orders the device would accept in the present mode
   always_comb begin
      allowed = 1'b0;
      if (fail_ff) begin
         allowed = (go_op == OP_RST);
      end else if (abort_ff) begin
         allowed = (go_op == OP_ABORT_RST);
      end else if (byp_ff) begin
         allowed = (go_op == OP_BYP_PGM) || (go_op == OP_BYP_EXIT);
      end else begin
         allowed = (go_op == OP_WORD) || (go_op == OP_BYP_ENTER) ||
                   (go_op == OP_RST) || (go_op == OP_ABORT_RST) ||
                   (go_op == OP_BUF && cnt_ff <= `FPC_BUF_MAX);
      end
   end

   // Bus cycle for the present step of the present order
   always_comb begin
      s_addr  = addr_ff;
      s_data  = data_ff;
      s_last  = 1'b0;
      buf_idx = step_ff[3:0] - 4'h4;
      unl     = (op_ff == OP_WORD) || (op_ff == OP_BYP_ENTER) ||
                (op_ff == OP_BUF) || (op_ff == OP_ABORT_RST);
      s_poll  = (op_ff == OP_WORD) || (op_ff == OP_BYP_PGM) || (op_ff == OP_BUF);
      poll_addr = (op_ff == OP_BUF) ? {addr_ff[21:4], cnt_ff[3:0]} : addr_ff;
      if (unl && step_ff == 6'h0) begin
         s_addr = UNLK_ADDR1;
         s_data = UNLK_DATA1;
      end else if (unl && step_ff == 6'h1) begin
         s_addr = UNLK_ADDR2;
         s_data = UNLK_DATA2;
      end else begin
         unique case (op_ff)
            OP_WORD: begin
               if (step_ff == 6'h2) begin
                  s_addr = UNLK_ADDR1;
                  s_data = `FPC_CMD_PGM;
               end else begin
                  s_last = 1'b1;
               end
            end
            OP_BYP_ENTER: begin
               s_addr = UNLK_ADDR1;
               s_data = `FPC_CMD_BYPASS;
               s_last = 1'b1;
            end
            OP_BYP_PGM: begin
               if (step_ff == 6'h0) begin
                  s_data = `FPC_CMD_PGM;
               end else begin
                  s_last = 1'b1;
               end
            end
            OP_BYP_EXIT: begin
               if (step_ff == 6'h0) begin
                  s_data = `FPC_CMD_EXIT1;
               end else begin
                  s_data = `FPC_CMD_EXIT2;
                  s_last = 1'b1;
               end
            end
            OP_RST: begin
               s_data = `FPC_CMD_RESET;
               s_last = 1'b1;
            end
            OP_ABORT_RST: begin
               s_addr = UNLK_ADDR1;
               s_data = `FPC_CMD_RESET;
               s_last = 1'b1;
            end
            OP_BUF: begin
               if (step_ff == 6'h2) begin
                  s_data = `FPC_CMD_LOAD;
               end else if (step_ff == 6'h3) begin
                  s_data = {11'h0, cnt_ff};
               end else if (step_ff < 6'h5 + {1'b0, cnt_ff}) begin
                  // cnt_ff + 1 loads, one per step, all inside one page
                  s_addr = {addr_ff[21:4], buf_idx};
                  s_data = buf_data;
               end else begin
                  s_data = `FPC_CMD_CONFIRM;
                  s_last = 1'b1;
               end
            end
            default: s_last = 1'b1;
         endcase
      end
   end

   // Sequencer: issue cycles, poll status, keep mode flags
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_ff          <= ST_IDLE;
         op_ff             <= OP_NONE;
         step_ff           <= 6'h0;
         cyc.req           <= 1'b0;
         cyc.wr            <= 1'b0;
         cyc.addr          <= 22'h0;
         cyc.wdata         <= 16'h0;
         r1_ff             <= 16'h0;
         rd_last_ff        <= 16'h0;
         hw_cnt_ff         <= 8'h0;
         hw_pend_ff        <= 1'b0;
         ok_ff             <= 1'b0;
         fail_ff           <= 1'b0;
         abort_ff          <= 1'b0;
         byp_ff            <= 1'b0;
         refused_ff        <= 1'b0;
         flash_reset_n_out <= 1'b1;
      end else if (ce_in) begin
         if (hw_pend_ff && !cyc.req) begin
            // Hardware reset ends any running operation
            hw_pend_ff        <= 1'b0;
            flash_reset_n_out <= 1'b0;
            hw_cnt_ff         <= 8'(`FPC_RP_CYC);
            state_ff          <= ST_HWRST;
         end else begin
            if (go && go_op == OP_HWRST) begin
               hw_pend_ff <= 1'b1;
               ok_ff      <= 1'b0;
               refused_ff <= 1'b0;
            end
            unique case (state_ff)
               ST_IDLE: begin
                  if (go && go_op != OP_HWRST) begin
                     if (allowed) begin
                        op_ff      <= go_op;
                        step_ff    <= 6'h0;
                        ok_ff      <= 1'b0;
                        refused_ff <= 1'b0;
                        state_ff   <= ST_ISSUE;
                     end else begin
                        refused_ff <= 1'b1;
                     end
                  end
               end
               ST_ISSUE: begin
                  if (!cyc.req) begin
                     cyc.req   <= 1'b1;
                     cyc.wr    <= 1'b1;
                     cyc.addr  <= s_addr;
                     cyc.wdata <= s_data;
                  end else if (cyc.ack) begin
                     cyc.req <= 1'b0;
                     if (!s_last) begin
                        step_ff <= step_ff + 6'h1;
                     end else if (s_poll) begin
                        state_ff <= ST_POLL1;
                     end else begin
                        ok_ff    <= 1'b1;
                        state_ff <= ST_IDLE;
                        unique case (op_ff)
                           OP_BYP_ENTER: byp_ff   <= 1'b1;
                           OP_BYP_EXIT:  byp_ff   <= 1'b0;
                           OP_RST:       fail_ff  <= 1'b0;
                           OP_ABORT_RST: abort_ff <= 1'b0;
                           default: ;
                        endcase
                     end
                  end
               end
               ST_POLL1, ST_POLL2: begin
                  if (!cyc.req) begin
                     cyc.req  <= 1'b1;
                     cyc.wr   <= 1'b0;
                     cyc.addr <= poll_addr;
                  end else if (cyc.ack) begin
                     cyc.req <= 1'b0;
                     if (state_ff == ST_POLL1) begin
                        r1_ff    <= cyc.rdata;
                        state_ff <= ST_POLL2;
                     end else begin
                        rd_last_ff <= cyc.rdata;
                        state_ff   <= ST_IDLE;
                        // Toggle stopped means done and back in read mode
                        if (r1_ff[`FPC_DQ_TOGGLE] == cyc.rdata[`FPC_DQ_TOGGLE]) begin
                           ok_ff <= 1'b1;
                        end else if (cyc.rdata[`FPC_DQ_FAIL]) begin
                           fail_ff <= 1'b1;
                        end else if (cyc.rdata[`FPC_DQ_ABORT]) begin
                           abort_ff <= 1'b1;
                        end else begin
                           state_ff <= ST_POLL1;
                        end
                     end
                  end
               end
               ST_HWRST: begin
                  if (hw_cnt_ff <= 8'h1) begin
                     flash_reset_n_out <= 1'b1;
                     byp_ff            <= 1'b0;
                     fail_ff           <= 1'b0;
                     abort_ff          <= 1'b0;
                     ok_ff             <= 1'b1;
                     state_ff          <= ST_IDLE;
                  end else begin
                     hw_cnt_ff <= hw_cnt_ff - 8'h1;
                  end
               end
            endcase
         end
      end
   end
endmodule : fpc_seq_top
`default_nettype wire

// ### hdl/fpc_wbuf.sv
// Sixteen-word staging store for buffered programming.
// Written from the register port, read by index in the sequencer.
`timescale 1ns/1ps
`default_nettype none
module fpc_wbuf (
   input  wire logic        clk_in,
   input  wire logic        ce_in,
   input  wire logic        wr_in,
   input  wire logic [3:0]  wr_idx_in,
   input  wire logic [15:0] wr_data_in,
   input  wire logic [3:0]  rd_idx_in,
   output logic [15:0]      rd_data_out
);
   logic [15:0] mem_ff [16];

   always_ff @(posedge clk_in) begin
      if (ce_in && wr_in) begin
         mem_ff[wr_idx_in] <= wr_data_in;
      end
   end

   assign rd_data_out = mem_ff[rd_idx_in];
endmodule : fpc_wbuf
`default_nettype wire
